// ===== cimlo_pkg.sv
// Package with encodings, widths and timing for the compact multiply/logic datapath.
package cimlo_pkg;
	localparam int XLEN      = 64;
	localparam int WORD      = 32;
	localparam int PROD      = 64;
	localparam int GPR_AW    = 5;
	localparam int CR_W      = 3;
	localparam logic [4:0] REG_REG_MAJOR_OP = 5'h1D;
	localparam logic [4:0] IMM8_MAJOR_OP    = 5'h0C;
	localparam logic [4:0] FN_SIGNED_MUL    = 5'h18;
	localparam logic [4:0] FN_UNSIGNED_MUL  = 5'h19;
	localparam logic [4:0] FN_NEGATE        = 5'h0B;
	localparam logic [4:0] FN_INVERT        = 5'h0F;
	localparam logic [4:0] FN_OR            = 5'h0D;
	localparam logic [2:0] SUB_MOVE_TO_WIDE = 3'h5;
	localparam logic [2:0] SUB_MOVE_FROM_WIDE = 3'h7;
	localparam logic [15:0] NOP_WORD        = 16'h6500;
	localparam int OP_HI = 15;
	localparam int OP_LO = 11;
	localparam int RX_HI = 10;
	localparam int RX_LO = 8;
	localparam int RY_HI = 7;
	localparam int RY_LO = 5;
	localparam int FN_HI = 4;
	localparam int FN_LO = 0;
	localparam int MUL_LAT = 4;
	localparam logic [2:0] MUL_LAT_W = 3'h4;
	localparam logic [XLEN-1:0] ZERO_X = 64'h0;
	localparam logic [GPR_AW-1:0] GPR_ZERO = 5'h00;
	localparam logic [WORD-1:0] ZERO_W = 32'h0;
	typedef enum logic [1:0] {
		CIMLO_MUL_IDLE,
		CIMLO_MUL_BUSY
	} cimlo_mul_state_t;
	// Compact register field translation.
	function automatic logic [GPR_AW-1:0] xlat(input logic [CR_W-1:0] f);
		logic [GPR_AW-1:0] r;
		r = 5'h00;
		unique case (f)
			3'h0: r = 5'h10;
			3'h1: r = 5'h11;
			3'h2: r = 5'h02;
			3'h3: r = 5'h03;
			3'h4: r = 5'h04;
			3'h5: r = 5'h05;
			3'h6: r = 5'h06;
			3'h7: r = 5'h07;
		endcase
		return r;
	endfunction
	function automatic logic [XLEN-1:0] sext_w(input logic [WORD-1:0] w);
		return {{(XLEN-WORD){w[WORD-1]}}, w};
	endfunction
endpackage

// ===== cimlo_mul_if.sv
// Interface between the control top and the multiplier unit.
`timescale 1ns/10ps
interface cimlo_mul_if;
	logic                  start;
	logic                  is_signed;
	logic [cimlo_pkg::WORD-1:0] op_a;
	logic [cimlo_pkg::WORD-1:0] op_b;
	logic                  done;
	logic [cimlo_pkg::PROD-1:0] product;
	modport ctrl (output start, is_signed, op_a, op_b, input done, product);
	modport unit (input start, is_signed, op_a, op_b, output done, product);
endinterface

// ===== cimlo_multiplier.sv
// Background 32x32 multiplier with fixed latency.
`timescale 1ns/10ps
module cimlo_multiplier (
	input  wire logic  clk_in,
	input  wire logic  rst_n,
	cimlo_mul_if.unit  mul
);
	logic [2:0]                  cnt_reg;
	logic [cimlo_pkg::PROD-1:0]  prod_reg;
	logic                        done_reg;
	wire  [cimlo_pkg::WORD:0]    ext_a;
	wire  [cimlo_pkg::WORD:0]    ext_b;
	wire  signed [cimlo_pkg::WORD*2+1:0] full;
	// Sign or zero extend per variant; zero for unsigned.
	assign ext_a = {mul.is_signed & mul.op_a[cimlo_pkg::WORD-1], mul.op_a};
	assign ext_b = {mul.is_signed & mul.op_b[cimlo_pkg::WORD-1], mul.op_b};
	assign full  = $signed(ext_a) * $signed(ext_b);
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg  <= 3'h0;
			prod_reg <= cimlo_pkg::ZERO_X;
			done_reg <= 1'b0;
		end else begin
			done_reg <= (cnt_reg == 3'h1);
			if (mul.start) begin
				// No overflow flag exists; full product kept.
				prod_reg <= full[cimlo_pkg::PROD-1:0];
				cnt_reg  <= cimlo_pkg::MUL_LAT_W;
			end else if (cnt_reg != 3'h0) begin
				cnt_reg <= cnt_reg - 3'h1;
			end
		end
	end
	assign mul.done    = done_reg;
	assign mul.product = prod_reg;
endmodule // cimlo_multiplier

// ===== cimlo_datapath.sv
// Top of the compact multiply, negate, invert, OR and move datapath.
// What this block does
// - Word with major 11101 and function 11000 is signed multiply.
// - Signed multiply forms a full 64-bit two's-complement product.
// - Product halves go sign-extended into product low and high registers.
// - Multiply never raises an arithmetic or overflow exception.
// - Function 11001 under major 11101 is unsigned multiply.
// - Unsigned multiply zero-extends both operand words first.
// - Product reads stall while a multiply is pending unless the issuing word is a move-from.
// - Function 01011 writes sign-extended zero minus second register.
// - Function 01111 writes the bitwise complement of second register.
// - Function 01101 writes first OR second into first register.
// - Word 0x6500 moves register 16 to register zero, no state change.
// - No-op is major 01100, sub-function 101, other bits zero.
// - The 5-bit wide field names any of the 32 registers.
`timescale 1ns/10ps
module cimlo_datapath (
	// Clock and reset
	input  wire logic                        clk_in,
	input  wire logic                        reset_n_in,
	// Instruction issue
	input  wire logic                        instr_valid_in,
	input  wire logic [15:0]                 instr_in,
	input  wire logic                        reads_product_low_in,
	input  wire logic                        reads_product_high_in,
	// Register file read ports
	output logic [cimlo_pkg::GPR_AW-1:0]     rd_addr_a_out,
	output logic [cimlo_pkg::GPR_AW-1:0]     rd_addr_b_out,
	input  wire logic [cimlo_pkg::XLEN-1:0]  rd_data_a_in,
	input  wire logic [cimlo_pkg::XLEN-1:0]  rd_data_b_in,
	// Register file write port
	output logic                             wr_en_out,
	output logic [cimlo_pkg::GPR_AW-1:0]     wr_addr_out,
	output logic [cimlo_pkg::XLEN-1:0]       wr_data_out,
	// Product registers and interlock
	output logic [cimlo_pkg::XLEN-1:0]       product_low_out,
	output logic [cimlo_pkg::XLEN-1:0]       product_high_out,
	output logic                             stall_out,
	output logic                             nop_out
);
	logic                          rs1_reg;
	logic                          rst_n;
	logic [cimlo_pkg::XLEN-1:0]    product_low_reg;
	logic [cimlo_pkg::XLEN-1:0]    product_high_reg;
	logic                          wr_en_reg;
	logic [cimlo_pkg::GPR_AW-1:0]  wr_addr_reg;
	logic [cimlo_pkg::XLEN-1:0]    wr_data_reg;
	logic [cimlo_pkg::GPR_AW-1:0]  rd_a_reg;
	logic [cimlo_pkg::GPR_AW-1:0]  rd_b_reg;
	logic                          stall_reg;
	logic                          nop_reg;
	logic                          ex_valid_reg;
	logic [15:0]                   ex_instr_reg;
	logic                          ex_is_mul;
	cimlo_pkg::cimlo_mul_state_t   mstate_reg;
	cimlo_pkg::cimlo_mul_state_t   mstate_next;
	cimlo_mul_if                   mul ();

	// Reset release through two flip-flops.
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rs1_reg <= 1'b0;
			rst_n   <= 1'b0;
		end else begin
			rs1_reg <= 1'b1;
			rst_n   <= rs1_reg;
		end
	end

	// Decode of the issuing word.
	wire [4:0] d_op  = instr_in[cimlo_pkg::OP_HI:cimlo_pkg::OP_LO];
	wire [4:0] d_fn  = instr_in[cimlo_pkg::FN_HI:cimlo_pkg::FN_LO];
	wire [2:0] d_sub = instr_in[cimlo_pkg::RX_HI:cimlo_pkg::RX_LO];
	wire [2:0] d_rx  = instr_in[cimlo_pkg::RX_HI:cimlo_pkg::RX_LO];
	wire [2:0] d_ry  = instr_in[cimlo_pkg::RY_HI:cimlo_pkg::RY_LO];
	wire       d_rr  = (d_op == cimlo_pkg::REG_REG_MAJOR_OP);
	wire       d_i8  = (d_op == cimlo_pkg::IMM8_MAJOR_OP);
	wire d_smul = d_rr && (d_fn == cimlo_pkg::FN_SIGNED_MUL);
	wire d_umul = d_rr && (d_fn == cimlo_pkg::FN_UNSIGNED_MUL);
	wire d_mul  = d_smul || d_umul;
	wire d_mvto = d_i8 && (d_sub == cimlo_pkg::SUB_MOVE_TO_WIDE);
	wire d_mvfr = d_i8 && (d_sub == cimlo_pkg::SUB_MOVE_FROM_WIDE);
	wire d_nop  = (instr_in == cimlo_pkg::NOP_WORD);
	// Wide source field of move-from reaches all 32 registers.
	// Only the read address is needed at issue; the wide destination of
	// move-to is taken from the execute copy of the word.
	wire [4:0] d_wide_src = instr_in[4:0];

	// Interlock on product reads while multiply is in flight.
	// The multiply counts as busy already in its execute cycle, before the
	// state register has moved; otherwise a read right behind it would slip
	// through and see the old product.
	wire busy      = (mstate_reg == cimlo_pkg::CIMLO_MUL_BUSY) ||
	                 (ex_valid_reg && ex_is_mul);
	wire prod_rd   = d_mvfr ? 1'b0 :
	                 (reads_product_low_in || reads_product_high_in);
	wire hazard    = instr_valid_in && busy && (prod_rd || d_mul);
	wire issue     = instr_valid_in && !hazard;

	// Compact fields translated before the register file.
	wire [4:0] a_next = d_mvfr ? d_wide_src : cimlo_pkg::xlat(d_rx);
	wire [4:0] b_next = d_mvto ? cimlo_pkg::xlat(instr_in[7:5])
	                           : cimlo_pkg::xlat(d_ry);

	// Busy from the execute cycle of a multiply until its product lands.
	always_comb begin
		mstate_next = mstate_reg;
		unique case (mstate_reg)
			cimlo_pkg::CIMLO_MUL_IDLE: begin
				if (ex_valid_reg && ex_is_mul)
					mstate_next = cimlo_pkg::CIMLO_MUL_BUSY;
			end
			cimlo_pkg::CIMLO_MUL_BUSY: begin
				if (mul.done)
					mstate_next = cimlo_pkg::CIMLO_MUL_IDLE;
			end
		endcase
	end

	// Execute stage decode, operands arrive from the register file now.
	wire [4:0] e_op  = ex_instr_reg[cimlo_pkg::OP_HI:cimlo_pkg::OP_LO];
	wire [4:0] e_fn  = ex_instr_reg[cimlo_pkg::FN_HI:cimlo_pkg::FN_LO];
	wire [2:0] e_sub = ex_instr_reg[cimlo_pkg::RX_HI:cimlo_pkg::RX_LO];
	wire       e_rr  = (e_op == cimlo_pkg::REG_REG_MAJOR_OP);
	wire       e_i8  = (e_op == cimlo_pkg::IMM8_MAJOR_OP);
	assign ex_is_mul = e_rr && ((e_fn == cimlo_pkg::FN_SIGNED_MUL) ||
	                            (e_fn == cimlo_pkg::FN_UNSIGNED_MUL));
	wire       e_signed  = (e_fn == cimlo_pkg::FN_SIGNED_MUL);
	wire       e_neg = e_rr && (e_fn == cimlo_pkg::FN_NEGATE);
	wire       e_not = e_rr && (e_fn == cimlo_pkg::FN_INVERT);
	wire       e_or  = e_rr && (e_fn == cimlo_pkg::FN_OR);
	wire       e_mvto = e_i8 && (e_sub == cimlo_pkg::SUB_MOVE_TO_WIDE);
	wire       e_mvfr = e_i8 && (e_sub == cimlo_pkg::SUB_MOVE_FROM_WIDE);
	wire [4:0] e_rx  = cimlo_pkg::xlat(ex_instr_reg[10:8]);
	wire [4:0] e_ry  = cimlo_pkg::xlat(ex_instr_reg[7:5]);
	// Wide destination of move-to names any of the 32 registers.
	wire [4:0] e_wide_dst = ex_instr_reg[4:0];
	// Negate keeps the low word, sign-extended, no trap.
	wire [cimlo_pkg::WORD-1:0] neg_w =
		cimlo_pkg::ZERO_W - rd_data_b_in[cimlo_pkg::WORD-1:0];
	wire [cimlo_pkg::XLEN-1:0] neg_x = cimlo_pkg::sext_w(neg_w);
	wire [cimlo_pkg::XLEN-1:0] not_x = ~rd_data_b_in;
	// Bitwise OR of first and second.
	wire [cimlo_pkg::XLEN-1:0] or_x  = rd_data_a_in | rd_data_b_in;
	wire [cimlo_pkg::XLEN-1:0] res_x =
		e_neg ? neg_x : e_not ? not_x : e_or ? or_x : rd_data_b_in;
	wire       e_wr   = ex_valid_reg && (e_neg || e_not || e_or ||
	                                     e_mvto || e_mvfr);
	wire [4:0] e_dst  = e_mvto ? e_wide_dst : e_mvfr ? e_ry : e_rx;
	// Writes to register zero are dropped, so 0x6500 changes nothing.
	wire       e_wr_ok = e_wr && (e_dst != cimlo_pkg::GPR_ZERO);
	wire [cimlo_pkg::XLEN-1:0] move_src = e_mvfr ? rd_data_a_in : rd_data_b_in;
	wire [cimlo_pkg::XLEN-1:0] wdata =
		(e_mvto || e_mvfr) ? move_src : res_x;

	assign mul.start     = ex_valid_reg && ex_is_mul;
	assign mul.is_signed = e_signed;
	assign mul.op_a      = rd_data_a_in[cimlo_pkg::WORD-1:0];
	assign mul.op_b      = rd_data_b_in[cimlo_pkg::WORD-1:0];

	cimlo_multiplier u_mul (
		.clk_in (clk_in),
		.rst_n  (rst_n),
		.mul    (mul)
	);

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			mstate_reg   <= cimlo_pkg::CIMLO_MUL_IDLE;
			ex_valid_reg <= 1'b0;
			ex_instr_reg <= 16'h0000;
			rd_a_reg     <= 5'h00;
			rd_b_reg     <= 5'h00;
			stall_reg    <= 1'b0;
			nop_reg      <= 1'b0;
		end else begin
			mstate_reg   <= mstate_next;
			ex_valid_reg <= issue;
			ex_instr_reg <= instr_in;
			rd_a_reg     <= a_next;
			rd_b_reg     <= b_next;
			stall_reg    <= hazard;
			nop_reg      <= issue && d_nop;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			wr_en_reg        <= 1'b0;
			wr_addr_reg      <= 5'h00;
			wr_data_reg      <= cimlo_pkg::ZERO_X;
			product_low_reg  <= cimlo_pkg::ZERO_X;
			product_high_reg <= cimlo_pkg::ZERO_X;
		end else begin
			wr_en_reg   <= e_wr_ok;
			wr_addr_reg <= e_dst;
			wr_data_reg <= wdata;
			// Product halves sign-extended into the product registers.
			if (mul.done) begin
				product_low_reg  <= cimlo_pkg::sext_w(mul.product[31:0]);
				product_high_reg <= cimlo_pkg::sext_w(mul.product[63:32]);
			end
		end
	end

	assign rd_addr_a_out    = a_next;
	assign rd_addr_b_out    = b_next;
	assign wr_en_out        = wr_en_reg;
	assign wr_addr_out      = wr_addr_reg;
	assign wr_data_out      = wr_data_reg;
	assign product_low_out  = product_low_reg;
	assign product_high_out = product_high_reg;
	assign stall_out        = stall_reg;
	assign nop_out          = nop_reg;
endmodule // cimlo_datapath

// ===== cimlo_datapath_sva.sv
// Port-level checks for the compact multiply and logic datapath.
`timescale 1ns/10ps
module cimlo_datapath_sva (
	input wire logic        clk_in,
	input wire logic        reset_n_in,
	input wire logic        instr_valid_in,
	input wire logic [15:0] instr_in,
	input wire logic        reads_product_low_in,
	input wire logic        reads_product_high_in,
	input wire logic [63:0] rd_data_a_in,
	input wire logic [63:0] rd_data_b_in,
	input wire logic [4:0]  rd_addr_a_out,
	input wire logic [4:0]  rd_addr_b_out,
	input wire logic        wr_en_out,
	input wire logic [4:0]  wr_addr_out,
	input wire logic [63:0] wr_data_out,
	input wire logic [63:0] product_low_out,
	input wire logic        stall_out,
	input wire logic        nop_out
);
	wire       rr_w  = instr_valid_in && instr_in[15:11] == 5'h1D;
	wire [4:0] fn_w  = instr_in[4:0];
	wire       mul_w = rr_w && fn_w[4:1] == 4'hC;
	wire       nop_w = instr_valid_in && instr_in == 16'h6500;
	wire       rdp_w = instr_valid_in &&
		(reads_product_low_in || reads_product_high_in);
	function automatic logic [63:0] sx(input logic [31:0] w);
		return {{32{w[31]}}, w};
	endfunction
	function automatic logic [4:0] xl(input logic [2:0] f);
		return (f < 3'h2) ? {2'h2, f} : {2'h0, f};
	endfunction
	default clocking @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	a_negate_result:
	assert property (rr_w && fn_w == 5'h0B |-> ##2 wr_en_out &&
		wr_data_out == sx(32'h0 - $past(rd_data_b_in[31:0])))
	else $error("negate result wrong");
	a_invert_result:
	assert property (rr_w && fn_w == 5'h0F |-> ##2 wr_en_out &&
		wr_data_out == ~$past(rd_data_b_in))
	else $error("invert result wrong");
	a_or_result:
	assert property (rr_w && fn_w == 5'h0D |-> ##2 wr_en_out &&
		wr_data_out == ($past(rd_data_a_in) | $past(rd_data_b_in)))
	else $error("or result wrong");
	a_stall_on_read:
	assert property (mul_w ##1 rdp_w |=> stall_out)
	else $error("product read not stalled");
	a_stall_bounded:
	assert property (stall_out |-> ##[1:8] !stall_out)
	else $error("stall does not end");
	a_product_cause:
	assert property (!$stable(product_low_out) |->
		$past(mul_w, 6) || $past(mul_w, 7))
	else $error("product changed without multiply");
	a_read_xlat:
	assert property (rr_w |-> rd_addr_a_out == xl(instr_in[10:8]) &&
		rd_addr_b_out == xl(instr_in[7:5]))
	else $error("register field translation wrong");
	a_nop_flag:
	assert property (nop_w |-> ##[1:2] nop_out)
	else $error("no-op not flagged");
	a_nop_no_write:
	assert property (nop_w |-> ##2 !wr_en_out)
	else $error("no-op wrote a register");
	a_write_nonzero:
	assert property (wr_en_out |-> wr_addr_out != 5'h00 &&
		$past(instr_valid_in, 2))
	else $error("bad register write");
	c_negate: cover property (rr_w && fn_w == 5'h0B);
	c_stall: cover property (mul_w ##1 rdp_w ##1 stall_out);
	c_nop: cover property (nop_w ##[1:2] nop_out);
endmodule // cimlo_datapath_sva
bind cimlo_datapath cimlo_datapath_sva cimlo_datapath_sva_inst (.*);

// ===== compact_isa_signed_word_multiply_logic_ops_bench.sv
// Self-checking bench for the compact multiply and logic datapath.
`timescale 1ns/10ps
module compact_isa_signed_word_multiply_logic_ops_bench;
	logic        clk_in = 1'b0;
	logic        reset_n_in;
	logic        instr_valid_in;
	logic [15:0] instr_in;
	logic        reads_product_low_in;
	logic        reads_product_high_in;
	logic [63:0] rd_data_a_in = 64'h0;
	logic [63:0] rd_data_b_in = 64'h0;
	logic [4:0]  rd_addr_a_out;
	logic [4:0]  rd_addr_b_out;
	logic        wr_en_out;
	logic [4:0]  wr_addr_out;
	logic [63:0] wr_data_out;
	logic [63:0] product_low_out;
	logic [63:0] product_high_out;
	logic        stall_out;
	logic        nop_out;
	logic [63:0] regs [32];
	logic [4:0]  fns [3] = '{5'h0B, 5'h0F, 5'h0D};
	int          error_cnt = 0;
	int          comparisons = 0;
	int          seed = 32'h35e07012;
	always #5 clk_in = ~clk_in;
	// Register file answers one cycle after the address, as the block expects.
	always @(posedge clk_in) begin
		rd_data_a_in <= regs[rd_addr_a_out];
		rd_data_b_in <= regs[rd_addr_b_out];
		if (wr_en_out === 1'b1)
			regs[wr_addr_out] <= wr_data_out;
	end
	cimlo_datapath cimlo_datapath_inst (.*);
	function automatic logic [4:0] xl(input logic [2:0] f);
		return (f < 3'h2) ? {2'h2, f} : {2'h0, f};
	endfunction
	function automatic logic [63:0] sx(input logic [31:0] w);
		return {{32{w[31]}}, w};
	endfunction
	task automatic final_report();
		if (error_cnt == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [63:0] got, exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic drive(input logic v, input logic [15:0] w,
		input logic [1:0] rp);
		@(posedge clk_in);
		instr_valid_in <= v;
		instr_in <= w;
		{reads_product_high_in, reads_product_low_in} <= rp;
	endtask
	task automatic wait_write();
		#1;
		for (int n = 0; n < 4 && wr_en_out !== 1'b1; n++) begin
			@(posedge clk_in);
			#1;
		end
		if (wr_en_out !== 1'b1) begin
			error_cnt++;
			$display("BAD %0t write missing", $time);
			final_report();
		end
	endtask
	task automatic run_move(input logic to, input logic [2:0] f,
		input logic [4:0] wide);
		logic [63:0] e;
		logic [4:0]  ea;
		logic [4:0]  d;
		@(posedge clk_in);
		#1;
		// A move into register zero writes nothing, so pick another.
		d = (to && wide == 5'h00) ? 5'h1F : wide;
		ea = to ? d : xl(f);
		e = to ? regs[xl(f)] : regs[d];
		drive(1'b1, {5'h0C, to ? 3'h5 : 3'h7, f, d}, 2'h0);
		drive(1'b0, 16'h0000, 2'h0);
		wait_write();
		chk(64'(wr_addr_out), 64'(ea));
		chk(wr_data_out, e);
	endtask
	task automatic run_logic(input logic [4:0] fn, input logic [2:0] rx, ry);
		logic [63:0] a, b, e;
		@(posedge clk_in);
		#1;
		a = regs[xl(rx)];
		b = regs[xl(ry)];
		e = (fn == 5'h0B) ? sx(32'h0 - b[31:0]) : (fn == 5'h0F) ? ~b : a | b;
		drive(1'b1, {5'h1D, rx, ry, fn}, 2'h0);
		drive(1'b0, 16'h0000, 2'h0);
		wait_write();
		chk(64'(wr_addr_out), 64'(xl(rx)));
		chk(wr_data_out, e);
	endtask
	task automatic run_mul(input logic u, input logic [2:0] rx, ry);
		logic [63:0] p;
		int          s;
		s = 0;
		// Let the last register write land before reading operands.
		@(posedge clk_in);
		#1;
		// Every register holds a sign-extended word, so signed needs no extension.
		p = u ? regs[xl(rx)][31:0] * regs[xl(ry)][31:0]
			: regs[xl(rx)] * regs[xl(ry)];
		drive(1'b1, {5'h1D, rx, ry, 4'hC, u}, 2'h0);
		drive(1'b1, 16'h0000, {u, ~u});
		repeat (8) begin
			@(posedge clk_in);
			#1;
			s += int'(stall_out === 1'b1);
		end
		drive(1'b0, 16'h0000, 2'h0);
		repeat (2) @(posedge clk_in);
		#1;
		chk(64'(s > 0), 64'h1);
		chk(product_low_out, sx(p[31:0]));
		chk(product_high_out, sx(p[63:32]));
	endtask
	initial begin
		int s;
		int w;
		reset_n_in = 1'b0;
		instr_valid_in = 1'b0;
		instr_in = 16'h0000;
		reads_product_low_in = 1'b0;
		reads_product_high_in = 1'b0;
		// Operands are kept as sign-extended words, as multiply needs.
		for (int i = 0; i < 32; i++)
			regs[i] = sx($random(seed));
		regs[0] = 64'h0;
		regs[2] = sx(32'h80000000);
		regs[3] = sx(32'hFFFFFFFF);
		repeat (8) @(posedge clk_in);
		reset_n_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		run_logic(5'h0B, 3'h4, 3'h2);
		run_logic(5'h0F, 3'h0, 3'h3);
		for (int i = 0; i < 36; i++)
			run_logic(fns[i % 3], 3'($random(seed)), 3'($random(seed)));
		for (int i = 0; i < 8; i++)
			run_move(i[0], 3'($random(seed)), 5'($random(seed)));
		run_mul(1'b0, 3'h2, 3'h2);
		run_mul(1'b1, 3'h3, 3'h3);
		for (int i = 0; i < 8; i++)
			run_mul(i[0], 3'($random(seed)), 3'($random(seed)));
		drive(1'b1, 16'h6500, 2'h0);
		drive(1'b0, 16'h0000, 2'h0);
		s = 0;
		w = 0;
		repeat (3) begin
			#1;
			s += int'(nop_out === 1'b1);
			w += int'(wr_en_out === 1'b1);
			@(posedge clk_in);
		end
		chk(64'(s), 64'h1);
		chk(64'(w), 64'h0);
		final_report();
	end
endmodule // compact_isa_signed_word_multiply_logic_ops_bench
